// >>> logic/sipp_pkg.sv
// shared constants and types of the serial download port
package sipp_pkg;

    // first frame byte of each command
    localparam logic [7:0] OP_ENABLE = 8'hac;
    localparam logic [7:0] OP_EXT_ADDR = 8'h4d;
    localparam logic [7:0] OP_FL_READ = 8'h20;
    localparam logic [7:0] OP_LOAD_PAGE = 8'h40;
    localparam logic [7:0] OP_WR_PAGE = 8'h4c;
    localparam logic [7:0] OP_EE_READ = 8'ha0;
    localparam logic [7:0] OP_EE_WRITE = 8'hc0;
    localparam logic [7:0] OP_POLL = 8'hf0;
    // second-byte keys
    localparam logic [7:0] ENABLE_KEY = 8'h53;
    localparam logic [2:0] ERASE_KEY = 3'h4;
    localparam logic [7:0] EXT_KEY = 8'h00;
    // high_byte_select position in byte 1
    localparam int HB_SEL_POS = 3;
    localparam logic [7:0] HB_SEL_MASK = 8'h08;

    // array geometry
    localparam int FLASH_WAW = 13;
    localparam int FLASH_BAW = FLASH_WAW + 1;
    localparam int EE_AW = 9;
    localparam int PAGE_WAW = 6;
    localparam int PAGE_BAW = PAGE_WAW + 1;
    localparam int PAGE_NUM_W = FLASH_WAW - PAGE_WAW;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // frame bit counter positions (bits already received)
    localparam logic [4:0] BYTE2_LAST = 5'h0f;
    localparam logic [4:0] BYTE3_LAST = 5'h17;
    localparam logic [4:0] FRAME_LAST = 5'h1f;

    // reset values
    localparam logic [7:0] EXT_RESET = 8'h00;
    localparam logic [7:0] TX_RESET = 8'h00;
    localparam logic DOUT_RESET = 1'b0;

    // self-timed durations
    localparam real CLK_PERIOD_NS = 20.0;
    localparam real FLASH_PAGE_WAIT_MS = 4.5;
    localparam real EEPROM_BYTE_WAIT_MS = 9.0;
    localparam real ERASE_WAIT_MS = 9.0;
    localparam int FLASH_PAGE_WAIT_CYC = int'($ceil(FLASH_PAGE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int EEPROM_BYTE_WAIT_CYC = int'($ceil(EEPROM_BYTE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int ERASE_WAIT_CYC = int'($ceil(ERASE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int WAIT_W = 20;
    localparam logic [WAIT_W-1:0] WAIT_IDLE = 20'h00000;

    typedef enum logic [1:0] {
        SIPP_W_FLASH = 2'b00,
        SIPP_W_EEPROM = 2'b01,
        SIPP_W_ERASE = 2'b10
    } sipp_wait_t;

    typedef struct packed {
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        logic [7:0] b4;
    } sipp_frame_t;

    // link-side state, cleared while the device reset pin is high
    typedef struct packed {
        logic [4:0] cnt;
        logic [31:0] sh;
        logic [7:0] tx;
        logic en;
        logic [7:0] ext;
    } sipp_link_st_t;

    // link-side event toggle, cleared only by rst_n so the far end stays aligned
    typedef struct packed {
        logic tog;
        sipp_wait_t kind;
    } sipp_evt_st_t;

    typedef struct packed {
        logic tog_seen;
        logic busy;
        logic [WAIT_W-1:0] wait_cnt;
    } sipp_core_st_t;

endpackage : sipp_pkg

// >>> logic/sipp_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sipp_sync
(
    // clock and clear
    input wire logic clk,
    input wire logic arst_n,
    // level
    input wire logic d,
    output logic q
);
    import sipp_pkg::*;

    logic [1:0] st_ff;
    logic [1:0] nxt_st;

    always_comb
    begin
        nxt_st = {st_ff[0], d};
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st_ff <= 2'h0;
        else
            st_ff <= nxt_st;
    end

    assign q = st_ff[1];
endmodule : sipp_sync
`default_nettype wire

// >>> logic/sipp_dout.sv
// falling-edge serial output stage
`timescale 1ns/1ps
`default_nettype none
module sipp_dout
(
    // link clock and clear
    input wire logic sck,
    input wire logic arst_n,
    // byte and bit position from the rising-edge logic
    input wire logic [7:0] tx_byte,
    input wire logic [2:0] bit_idx,
    // pin
    output logic serial_data_out
);
    import sipp_pkg::*;

    logic dout_ff;
    logic nxt_dout;

    always_comb
    begin
        nxt_dout = tx_byte[3'h7 - bit_idx];
    end

    always_ff @(negedge sck or negedge arst_n)
    begin
        if (!arst_n)
            dout_ff <= DOUT_RESET;
        else
            dout_ff <= nxt_dout;
    end

    assign serial_data_out = dout_ff;
endmodule : sipp_dout
`default_nettype wire

// >>> logic/sipp_port.sv
// serial download port: frame engine, arrays and self-timed busy
//
// Function
// - port works only while device reset pin is low; sck, data in, data out
// - erase and writes refused until programming enable succeeded
// - eeprom byte write self-timed with built-in erase, one byte per frame
// - chip erase sets all flash and eeprom bytes to 0xff
// - serial_data_in sampled on sck rising edge
// - serial_data_out changes on sck falling edge
// - byte 2 of enable echoed during byte 3; retry via reset pulse
// - flash written per page; buffer loaded low byte then high byte
// - write page commits buffer at extended:byte2:byte3 top bits
// - extended address byte kept until replaced or reset pin high; placed on top of read and write addresses, all its bits drop off at this size
// - read commands return addressed flash or eeprom content
// - releasing reset high ends programming mode
// - enable frame is 0xac 0x53, last two bytes ignored
// - 0xac then 100x xxxx starts chip erase
// - 0x4d 0x00 loads byte 3 into extended address byte
// - 0010 H000 reads flash byte at word address, returned in byte 4
// - 0100 H000 writes byte 4 into page buffer at byte 3 low six bits
// - 0xa0 reads eeprom at byte2 bit 0:byte3, returned in byte 4
// - poll 0xf0 returns busy_flag in bit 0 of byte 4
`timescale 1ns/1ps
`default_nettype none
module sipp_port
#(
    parameter int unsigned FLASH_WAIT_CYC = sipp_pkg::FLASH_PAGE_WAIT_CYC,
    parameter int unsigned EEPROM_WAIT_CYC = sipp_pkg::EEPROM_BYTE_WAIT_CYC,
    parameter int unsigned ERASE_CYC = sipp_pkg::ERASE_WAIT_CYC
)
(
    // cpu clock and block reset
    input wire logic mclk,
    input wire logic rst_n,
    // device reset pin level, low while programming
    input wire logic ext_reset_n,
    // serial link
    input wire logic sck,
    input wire logic serial_data_in,
    output logic serial_data_out,
    // status on mclk
    output logic prog_enabled,
    output logic busy_flag
);
    import sipp_pkg::*;

    // arrays, held in the link domain so reads answer within one bit time
    logic [7:0] flash_mem [0:(2**FLASH_BAW)-1];
    logic [7:0] ee_mem [0:(2**EE_AW)-1];
    logic [7:0] page_buf [0:(2**PAGE_BAW)-1];

    sipp_link_st_t lk_ff;
    sipp_link_st_t nxt_lk;
    sipp_evt_st_t ev_ff;
    sipp_evt_st_t nxt_ev;
    sipp_core_st_t core_ff;
    sipp_core_st_t nxt_core;

    logic link_arst_n;
    logic busy_lk;
    logic tog_mc;
    logic [31:0] nsh;
    sipp_frame_t fr;
    logic [FLASH_BAW-1:0] rd_fl_idx;
    logic [EE_AW-1:0] ee_idx;
    logic [FLASH_WAW-1:0] wr_word;
    logic [PAGE_NUM_W-1:0] wr_page;
    logic [PAGE_BAW-1:0] ld_idx;
    logic frame_end;
    logic wr_ok;
    logic hb_sel;
    logic do_erase;
    logic do_ee_wr;
    logic do_load;
    logic do_page;
    logic [7:0] resp;

    // link state only lives while the reset pin is held low
    // reset pin high drops programming mode at once
    assign link_arst_n = rst_n & ~ext_reset_n;

    // shift register fed on sck rising edge, msb first
    assign nsh = {lk_ff.sh[30:0], serial_data_in};
    assign fr = sipp_frame_t'(nsh);
    assign frame_end = (lk_ff.cnt == FRAME_LAST);
    assign hb_sel = fr.b1[HB_SEL_POS];

    // byte 4 answer; at this point fr.b2 to fr.b4 hold bytes 1..3 shifted down one
    always_comb
    begin
        // extended byte on top; bits past the array size drop off
        rd_fl_idx = {FLASH_WAW'({lk_ff.ext, nsh[15:0]}), nsh[16+HB_SEL_POS]};
        ee_idx = nsh[EE_AW-1:0];
        resp = nsh[7:0];
        // flash read at extended:byte2:byte3, half per high_byte_select
        if ((nsh[23:16] & ~HB_SEL_MASK) == OP_FL_READ)
            resp = flash_mem[rd_fl_idx];
        else if (nsh[23:16] == OP_EE_READ)
            resp = ee_mem[ee_idx];
        else if (nsh[23:16] == OP_POLL)
            resp = {7'h00, busy_lk};
    end

    // write decode, acted on at the last bit of the frame
    always_comb
    begin
        // no array or page buffer is written before enable or while a write is timing out
        wr_ok = frame_end && lk_ff.en && !busy_lk;
        // erase on 0xac and 100x xxxx
        do_erase = wr_ok && (fr.b1 == OP_ENABLE) && (fr.b2[7:5] == ERASE_KEY);
        // one eeprom byte per frame, address and data together
        do_ee_wr = wr_ok && (fr.b1 == OP_EE_WRITE);
        // page buffer load on 0100 H000
        do_load = wr_ok && ((fr.b1 & ~HB_SEL_MASK) == OP_LOAD_PAGE);
        do_page = wr_ok && (fr.b1 == OP_WR_PAGE);
        // low and high halves sit side by side per word
        ld_idx = {fr.b3[PAGE_WAW-1:0], hb_sel};
        // extended byte on top; at this array size all its bits drop off
        wr_word = FLASH_WAW'({lk_ff.ext, fr.b2, fr.b3[7:6], {PAGE_WAW{1'b0}}});
        wr_page = wr_word[FLASH_WAW-1:PAGE_WAW];
    end

    always_comb
    begin
        nxt_lk = lk_ff;
        nxt_lk.sh = nsh;
        // frames run back to back, counter wraps every 32 bits
        nxt_lk.cnt = lk_ff.cnt + 5'h01;
        // each finished byte is echoed during the next byte
        if (lk_ff.cnt[2:0] == 3'h7)
            nxt_lk.tx = nsh[7:0];
        // read result fills the byte 4 slot
        if (lk_ff.cnt == BYTE3_LAST)
            nxt_lk.tx = resp;
        // enable needs only bytes 1 and 2
        if ((lk_ff.cnt == BYTE2_LAST) && (nsh[15:8] == OP_ENABLE) && (nsh[7:0] == ENABLE_KEY))
            nxt_lk.en = 1'b1;
        // extended address load, byte 4 ignored
        if (frame_end && lk_ff.en && (fr.b1 == OP_EXT_ADDR) && (fr.b2 == EXT_KEY))
            nxt_lk.ext = fr.b3;
    end

    always_ff @(posedge sck or negedge link_arst_n)
    begin
        if (!link_arst_n)
        begin
            lk_ff.cnt <= 5'h00;
            lk_ff.sh <= 32'h00000000;
            lk_ff.tx <= TX_RESET;
            lk_ff.en <= 1'b0;
            lk_ff.ext <= EXT_RESET;
        end
        else
            lk_ff <= nxt_lk;
    end

    // event toggle toward mclk; never cleared by the reset pin so no false edge
    always_comb
    begin
        nxt_ev = ev_ff;
        if (do_erase || do_ee_wr || do_page)
        begin
            nxt_ev.tog = ~ev_ff.tog;
            if (do_erase)
                nxt_ev.kind = SIPP_W_ERASE;
            else if (do_ee_wr)
                nxt_ev.kind = SIPP_W_EEPROM;
            else
                nxt_ev.kind = SIPP_W_FLASH;
        end
    end

    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ev_ff.tog <= 1'b0;
            ev_ff.kind <= SIPP_W_FLASH;
        end
        else
            ev_ff <= nxt_ev;
    end

    // array updates; writes land at once, busy models the self-timed cycle
    always_ff @(posedge sck)
    begin
        // chip erase fills both arrays with ones
        if (do_erase)
        begin
            for (int i = 0; i < 2**FLASH_BAW; i++)
                flash_mem[i] <= ERASED_BYTE;
            for (int j = 0; j < 2**EE_AW; j++)
                ee_mem[j] <= ERASED_BYTE;
        end
        // overwrite replaces the old byte, no prior erase needed
        if (do_ee_wr)
            ee_mem[fr.b2[EE_AW-9:0] == 1'b0 ? {1'b0, fr.b3} : {1'b1, fr.b3}] <= fr.b4;
        if (do_load)
            page_buf[ld_idx] <= fr.b4;
        // whole page committed in one step
        if (do_page)
        begin
            for (int k = 0; k < 2**PAGE_BAW; k++)
                flash_mem[{wr_page, PAGE_BAW'(k)}] <= page_buf[k];
        end
    end

    // busy crosses into the link domain for polls
    sipp_sync u_busy_sync
    (
        .clk(sck),
        .arst_n(link_arst_n),
        .d(core_ff.busy),
        .q(busy_lk)
    );

    sipp_dout u_dout
    (
        .sck(sck),
        .arst_n(link_arst_n),
        .tx_byte(lk_ff.tx),
        .bit_idx(lk_ff.cnt[2:0]),
        .serial_data_out(serial_data_out)
    );

    sipp_sync u_evt_sync
    (
        .clk(mclk),
        .arst_n(rst_n),
        .d(ev_ff.tog),
        .q(tog_mc)
    );

    sipp_sync u_en_sync
    (
        .clk(mclk),
        .arst_n(rst_n),
        .d(lk_ff.en),
        .q(prog_enabled)
    );

    // self-timed duration per write kind; kind is stable long before the edge
    always_comb
    begin
        nxt_core = core_ff;
        nxt_core.tog_seen = tog_mc;
        if (core_ff.wait_cnt != WAIT_IDLE)
            nxt_core.wait_cnt = core_ff.wait_cnt - 20'h00001;
        if (tog_mc != core_ff.tog_seen)
        begin
            unique case (ev_ff.kind)
                SIPP_W_FLASH: nxt_core.wait_cnt = WAIT_W'(FLASH_WAIT_CYC);
                SIPP_W_EEPROM: nxt_core.wait_cnt = WAIT_W'(EEPROM_WAIT_CYC);
                SIPP_W_ERASE: nxt_core.wait_cnt = WAIT_W'(ERASE_CYC);
                default: nxt_core.wait_cnt = WAIT_W'(ERASE_CYC);
            endcase
        end
        nxt_core.busy = (nxt_core.wait_cnt != WAIT_IDLE);
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            core_ff.tog_seen <= 1'b0;
            core_ff.busy <= 1'b0;
            core_ff.wait_cnt <= WAIT_IDLE;
        end
        else
            core_ff <= nxt_core;
    end

    assign busy_flag = core_ff.busy;
endmodule : sipp_port
`default_nettype wire

// >>> dv/sipp_port_properties.sv
// pin-level assertions of the serial download port
`timescale 1ns/1ps
`default_nettype none
module sipp_port_properties
#(
    parameter int unsigned FLASH_WAIT_CYC = 20,
    parameter int unsigned EEPROM_WAIT_CYC = 20,
    parameter int unsigned ERASE_CYC = 20
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // link pins
    input wire logic ext_reset_n,
    input wire logic sck,
    input wire logic serial_data_in,
    input wire logic serial_data_out,
    // status
    input wire logic prog_enabled,
    input wire logic busy_flag
);
    // slack for the toggle crossing into mclk
    localparam int unsigned LO = FLASH_WAIT_CYC - 1;
    localparam int unsigned HI = (EEPROM_WAIT_CYC > ERASE_CYC ? EEPROM_WAIT_CYC : ERASE_CYC) + 2;
    logic [19:0] busy_cnt_ff;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge mclk)
    begin
        busy_cnt_ff <= busy_flag ? busy_cnt_ff + 20'h1 : 20'h0;
    end
    chk_out_cleared: assert property (ext_reset_n |-> !serial_data_out)
        else $error("data out not idle while link cleared");
    chk_out_on_fall: assert property ($changed(serial_data_out) |->
        !sck || ext_reset_n || $past(ext_reset_n)) else $error("data out moved with clock high");
    chk_en_drop: assert property ($rose(ext_reset_n) |-> ##[1:5] !prog_enabled)
        else $error("enable kept after reset pin high");
    chk_en_kept: assert property ($fell(prog_enabled) |-> $past(ext_reset_n, 2)
        || $past(ext_reset_n, 3) || $past(ext_reset_n, 4)) else $error("enable lost unasked");
    chk_en_in_session: assert property ($rose(prog_enabled) |-> !$past(ext_reset_n, 3))
        else $error("enable outside session");
    chk_busy_needs_en: assert property ($rose(busy_flag) |-> prog_enabled)
        else $error("write started without enable");
    chk_busy_holds: assert property ($rose(busy_flag) |-> busy_flag[*8])
        else $error("busy dropped early");
    chk_busy_len: assert property ($fell(busy_flag) |-> busy_cnt_ff >= LO && busy_cnt_ff <= HI)
        else $error("self-timed length wrong");
    cover property ($rose(prog_enabled));
    cover property ($fell(busy_flag));
    cover property ($rose(ext_reset_n) ##1 prog_enabled);
endmodule : sipp_port_properties
bind sipp_port sipp_port_properties #(.FLASH_WAIT_CYC(FLASH_WAIT_CYC),
    .EEPROM_WAIT_CYC(EEPROM_WAIT_CYC), .ERASE_CYC(ERASE_CYC)) sipp_port_properties_inst (
    .mclk(mclk), .rst_n(rst_n), .ext_reset_n(ext_reset_n), .sck(sck),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .prog_enabled(prog_enabled), .busy_flag(busy_flag));
`default_nettype wire

// >>> dv/sipp_prog_model.sv
// external programmer model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module sipp_prog_model
#(
    // phase length set by HALF_NS, the model drives sck; the port runs on sck itself
    parameter real HALF_NS = 24.0
)
(
    // link towards the device
    output logic sck,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    initial
    begin
        sck = 1'b0;
        serial_data_in = 1'b0;
    end
    task automatic send(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--)
        begin
            serial_data_in = tx[i];
            #(HALF_NS);
            rx = {rx[30:0], serial_data_out};
            sck = 1'b1;
            #(HALF_NS);
            sck = 1'b0;
        end
        // released line must not look stale
        serial_data_in = ~serial_data_in;
    endtask : send
endmodule : sipp_prog_model
`default_nettype wire

// >>> dv/test_sipp_port.sv
// self-checking bench of the serial download port
`timescale 1ns/1ps
`default_nettype none
module test_sipp_port;
    import sipp_pkg::*;
    localparam int unsigned W_FL = 120;
    localparam int unsigned W_EE = 200;
    logic mclk = 1'b0;
    // stepped at 1 ns so the asynchronous clears see a real edge
    logic rst_n = 1'b1;
    logic ext_reset_n = 1'b0;
    logic sck;
    logic sdi;
    logic sdo;
    logic prog_enabled;
    logic busy_flag;
    logic [31:0] rx;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    // frame, then expected byte 4
    logic [39:0] rows [12] = '{
        {OP_EE_READ, 8'h01, 8'h05, 8'h00, 8'hff},
        {OP_FL_READ, 8'h01, 8'h43, 8'h00, 8'hff},
        {OP_EXT_ADDR, EXT_KEY, 8'h00, 8'h00, 8'h00},
        {OP_LOAD_PAGE, 8'h00, 8'h03, 8'ha5, 8'h03},
        {OP_LOAD_PAGE | HB_SEL_MASK, 8'h00, 8'h03, 8'h3c, 8'h03},
        {OP_WR_PAGE, 8'h01, 8'h40, 8'h00, 8'h40},
        {OP_FL_READ, 8'h01, 8'h43, 8'h00, 8'ha5},
        {OP_FL_READ | HB_SEL_MASK, 8'h01, 8'h43, 8'h00, 8'h3c},
        {OP_FL_READ, 8'h01, 8'h83, 8'h00, 8'hff},
        {OP_EE_WRITE, 8'h01, 8'h05, 8'h5a, 8'h05},
        {OP_EE_WRITE, 8'h01, 8'h05, 8'ha5, 8'h05},
        {OP_EE_READ, 8'h01, 8'h05, 8'h00, 8'ha5}};
    always #10 mclk = ~mclk;
    sipp_port #(.FLASH_WAIT_CYC(W_FL), .EEPROM_WAIT_CYC(W_EE), .ERASE_CYC(W_EE)) sipp_port_inst (
        .mclk(mclk), .rst_n(rst_n), .ext_reset_n(ext_reset_n), .sck(sck),
        .serial_data_in(sdi), .serial_data_out(sdo),
        .prog_enabled(prog_enabled), .busy_flag(busy_flag));
    sipp_prog_model sipp_prog_model_inst (.sck(sck), .serial_data_in(sdi), .serial_data_out(sdo));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic frame(input logic [31:0] tx);
        @(negedge mclk);
        sipp_prog_model_inst.send(tx, rx);
    endtask : frame
    task automatic pause();
        repeat (10) @(negedge mclk);
    endtask : pause
    // bounded wait for the self-timed cycle
    task automatic settle();
        pause();
        for (int i = 0; i < 1000 && busy_flag !== 1'b0; i++)
            @(negedge mclk);
        chk({7'h0, busy_flag}, 8'h00);
    endtask : settle
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 10000)
        begin
            error_cnt++;
            end_of_test();
        end
    end
    initial
    begin
        #1;
        rst_n = 1'b0;
        ext_reset_n = 1'b1;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        ext_reset_n = 1'b0;
        chk({6'h0, prog_enabled, busy_flag}, 8'h00);
        // power-up wait shortened; the port does not time it
        frame({OP_ENABLE, 8'h80, 16'h0});
        pause();
        chk({6'h0, prog_enabled, busy_flag}, 8'h00);
        frame({OP_ENABLE, ENABLE_KEY, 16'h0});
        chk(rx[15:8], ENABLE_KEY);
        pause();
        chk({7'h0, prog_enabled}, 8'h01);
        frame({OP_ENABLE, 8'h9f, 16'hffff});
        pause();
        chk({7'h0, busy_flag}, 8'h01);
        settle();
        foreach (rows[i])
        begin
            frame(rows[i][39:8]);
            chk(rx[7:0], rows[i][7:0]);
            settle();
        end
        frame({OP_EE_WRITE, 8'h00, 8'h10, 8'h77});
        frame({OP_POLL, 24'h0});
        chk({7'h0, rx[0]}, 8'h01);
        settle();
        frame({OP_POLL, 24'h0});
        chk({7'h0, rx[0]}, 8'h00);
        ext_reset_n = 1'b1;
        repeat (6) @(negedge mclk);
        chk({7'h0, prog_enabled}, 8'h00);
        ext_reset_n = 1'b0;
        frame({OP_EE_WRITE, 8'h00, 8'h10, 8'h00});
        pause();
        chk({7'h0, busy_flag}, 8'h00);
        // one stray bit puts the link out of step
        frame({1'b0, OP_ENABLE, ENABLE_KEY, 15'h0});
        chk(rx[15:8], 8'h29);
        pause();
        chk({7'h0, prog_enabled}, 8'h00);
        ext_reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        ext_reset_n = 1'b0;
        frame({OP_ENABLE, ENABLE_KEY, 16'h0});
        chk(rx[15:8], ENABLE_KEY);
        frame({OP_EE_READ, 8'h00, 8'h10, 8'h00});
        chk(rx[7:0], 8'h77);
        end_of_test();
    end
endmodule : test_sipp_port
`default_nettype wire
